// ### logic/input_capture_control.v
// Input capture channel control register, capture FIFO and AXI4-Lite slave
//
// Chosen here: the address map and the AXI4-Lite register port.
`include "input_capture_control_defs.vh"
`default_nettype none

module input_capture_control (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // AXI4-Lite write address and data
    input wire awvalid,
    output reg awready,
    input wire [7:0] awaddr,
    input wire wvalid,
    output reg wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // AXI4-Lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // AXI4-Lite read
    input wire arvalid,
    output reg arready,
    input wire [7:0] araddr,
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // Capture pin, time bases and power state
    input wire capturePinIn,
    input wire [15:0] secondTimerCount,
    input wire [15:0] thirdTimerCount,
    input wire cpuIdle,
    input wire cpuSleep,
    // Events
    output reg captureInterrupt,
    output reg wakeInterrupt
);

    // Modes 000, 110 and 111 never fill the buffer
    function capture_mode;
        input [2:0] mode;
        begin
            capture_mode = (mode != `MODE_OFF) && (mode != `MODE_UNUSED) &&
                (mode != `MODE_WAKE_ONLY);
        end
    endfunction

    // Register decode; is_control is shared by the write and read sides, is_buffer serves the read side only
    function is_control;
        input [7:0] addr;
        begin
            is_control = (addr == `ADDR_CONTROL);
        end
    endfunction

    function is_buffer;
        input [7:0] addr;
        begin
            is_buffer = (addr == `ADDR_BUFFER);
        end
    endfunction

    reg haltWhenIdle;
    reg timeBaseSelect;
    reg [1:0] eventsPerInterrupt;
    reg [2:0] captureModeField;
    reg overflowFlag;
    reg [15:0] fifoMem [0:3];
    reg [1:0] writePtr;
    reg [1:0] readPtr;
    reg [2:0] fifoCount;
    reg pinPrev;
    reg [3:0] prescaleCount;
    reg [1:0] eventCount;
    reg awHeld;
    reg wHeld;
    reg [7:0] awAddrHeld;
    reg [31:0] wDataHeld;
    reg [3:0] wStrbHeld;

    wire bufferNotEmptyFlag = (fifoCount != 3'h0);
    wire [15:0] controlReset = `CONTROL_RESET;

    // Status bits come from hardware flags, so no write path can reach them
    reg [15:0] controlWord;
    always @* begin
        controlWord = 16'h0000;
        controlWord[`BIT_HALT_IDLE] = haltWhenIdle;
        controlWord[`BIT_TIME_BASE] = timeBaseSelect;
        controlWord[`FIELD_EPI_HI:`FIELD_EPI_LO] = eventsPerInterrupt;
        controlWord[`BIT_OVERFLOW] = overflowFlag;
        controlWord[`BIT_NOT_EMPTY] = bufferNotEmptyFlag;
        controlWord[`FIELD_MODE_HI:`FIELD_MODE_LO] = captureModeField;
    end

    // Write channel bookkeeping
    wire awTaken = awvalid && awready;
    wire wTaken = wvalid && wready;
    wire next_awHeld = awHeld || awTaken;
    wire next_wHeld = wHeld || wTaken;
    wire [7:0] wrAddr = awHeld ? awAddrHeld : awaddr;
    wire [31:0] wrData = wHeld ? wDataHeld : wdata;
    wire [3:0] wrStrb = wHeld ? wStrbHeld : wstrb;
    wire doWrite = next_awHeld && next_wHeld && !bvalid;
    wire writeCtrl = doWrite && is_control(wrAddr);
    wire next_bvalid = doWrite || (bvalid && !bready);

    // Read channel
    wire arTaken = arvalid && arready;
    wire next_rvalid = arTaken || (rvalid && !rready);
    wire popBuffer = arTaken && is_buffer(araddr) && bufferNotEmptyFlag;

    // Pin events
    wire rise = capturePinIn && !pinPrev;
    wire fall = !capturePinIn && pinPrev;
    wire halted = haltWhenIdle && cpuIdle;
    wire running = capture_mode(captureModeField) && !halted;
    reg edgeHit;
    reg [3:0] prescaleTop;
    reg usePrescale;
    always @* begin
        edgeHit = 1'b0;
        usePrescale = 1'b0;
        prescaleTop = `PRESCALE_4TH;
        case (captureModeField)
            `MODE_EVERY_EDGE: edgeHit = rise || fall;
            `MODE_FALLING: edgeHit = fall;
            `MODE_RISING: edgeHit = rise;
            `MODE_RISING_4TH: begin
                edgeHit = rise;
                usePrescale = 1'b1;
            end
            `MODE_RISING_16TH: begin
                edgeHit = rise;
                usePrescale = 1'b1;
                prescaleTop = `PRESCALE_16TH;
            end
            default: edgeHit = 1'b0;
        endcase
    end
    wire edgeSeen = running && edgeHit;
    wire captureEvent = edgeSeen && (!usePrescale || (prescaleCount == prescaleTop));
    wire fifoFull = (fifoCount == `FIFO_DEPTH);
    wire pushBuffer = captureEvent && !fifoFull;
    // Time base select: one picks the second timer, whole 16-bit count
    wire [15:0] capturedCount = timeBaseSelect ? secondTimerCount : thirdTimerCount;

    // Control register; status bits are not software-writable
    always @(posedge mclk) begin
        if (srst) begin
            haltWhenIdle <= controlReset[`BIT_HALT_IDLE];
            timeBaseSelect <= controlReset[`BIT_TIME_BASE];
            eventsPerInterrupt <= controlReset[`FIELD_EPI_HI:`FIELD_EPI_LO];
            captureModeField <= controlReset[`FIELD_MODE_HI:`FIELD_MODE_LO];
        end else if (writeCtrl) begin
            if (wrStrb[1]) begin
                haltWhenIdle <= wrData[`BIT_HALT_IDLE];
            end
            if (wrStrb[0]) begin
                timeBaseSelect <= wrData[`BIT_TIME_BASE];
                eventsPerInterrupt <= wrData[`FIELD_EPI_HI:`FIELD_EPI_LO];
                captureModeField <= wrData[`FIELD_MODE_HI:`FIELD_MODE_LO];
            end
        end
    end

    // Overflow: set by a capture into a full buffer, cleared by turning the channel off
    always @(posedge mclk) begin
        if (srst) begin
            overflowFlag <= 1'b0;
        end else if (captureEvent && fifoFull) begin
            overflowFlag <= 1'b1;
        end else if (captureModeField == `MODE_OFF) begin
            overflowFlag <= 1'b0;
        end
    end

    // Capture FIFO; a full buffer drops the new value and keeps the old ones
    always @(posedge mclk) begin
        if (pushBuffer) begin
            fifoMem[writePtr] <= capturedCount;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            writePtr <= 2'h0;
            readPtr <= 2'h0;
            fifoCount <= 3'h0;
        end else begin
            if (pushBuffer) begin
                writePtr <= writePtr + 2'h1;
            end
            if (popBuffer) begin
                readPtr <= readPtr + 2'h1;
            end
            if (pushBuffer && !popBuffer) begin
                fifoCount <= fifoCount + 3'h1;
            end else if (popBuffer && !pushBuffer) begin
                fifoCount <= fifoCount - 3'h1;
            end
        end
    end

    // Edge history, prescaler and events-per-interrupt counter
    always @(posedge mclk) begin
        if (srst) begin
            pinPrev <= 1'b0;
            prescaleCount <= 4'h0;
            eventCount <= 2'h0;
            captureInterrupt <= 1'b0;
            wakeInterrupt <= 1'b0;
        end else begin
            pinPrev <= capturePinIn;
            captureInterrupt <= 1'b0;
            // Wake mode ignores every other control bit, stop-in-idle included
            wakeInterrupt <= (captureModeField == `MODE_WAKE_ONLY) && rise &&
                (cpuSleep || cpuIdle);
            if (!capture_mode(captureModeField) || writeCtrl) begin
                // A mode change restarts counting so stale partial counts never fire
                prescaleCount <= 4'h0;
                eventCount <= 2'h0;
            end else begin
                if (edgeSeen && usePrescale) begin
                    prescaleCount <= (prescaleCount == prescaleTop) ? 4'h0 :
                        prescaleCount + 4'h1;
                end
                if (captureEvent) begin
                    if (eventCount == eventsPerInterrupt) begin
                        eventCount <= 2'h0;
                        captureInterrupt <= 1'b1;
                    end else begin
                        eventCount <= eventCount + 2'h1;
                    end
                end
            end
        end
    end

    // AXI4-Lite write side
    always @(posedge mclk) begin
        if (srst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrHeld <= 8'h00;
            wDataHeld <= 32'h00000000;
            wStrbHeld <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            if (awTaken) begin
                awAddrHeld <= awaddr;
            end
            if (wTaken) begin
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
            awHeld <= next_awHeld && !doWrite;
            wHeld <= next_wHeld && !doWrite;
            awready <= !(next_awHeld && !doWrite) && !next_bvalid;
            wready <= !(next_wHeld && !doWrite) && !next_bvalid;
            bvalid <= next_bvalid;
            if (doWrite) begin
                bresp <= is_control(wrAddr) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // AXI4-Lite read side; reading a non-empty buffer pops one value
    always @(posedge mclk) begin
        if (srst) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else begin
            arready <= !next_rvalid;
            rvalid <= next_rvalid;
            if (arTaken) begin
                rresp <= `RESP_OKAY;
                if (is_control(araddr)) begin
                    rdata <= {16'h0000, controlWord};
                end else if (is_buffer(araddr)) begin
                    rdata <= bufferNotEmptyFlag ? {16'h0000, fifoMem[readPtr]} :
                        32'h00000000;
                end else begin
                    rdata <= 32'h00000000;
                    rresp <= `RESP_SLVERR;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### logic/input_capture_control_defs.vh
// Offsets, field positions, reset values and codes of the capture channel
`ifndef INPUT_CAPTURE_CONTROL_DEFS_VH
`define INPUT_CAPTURE_CONTROL_DEFS_VH

`define ADDR_CONTROL 8'h00
`define ADDR_BUFFER 8'h04

`define CONTROL_RESET 16'h0000
`define BIT_HALT_IDLE 13
`define BIT_TIME_BASE 7
`define FIELD_EPI_HI 6
`define FIELD_EPI_LO 5
`define BIT_OVERFLOW 4
`define BIT_NOT_EMPTY 3
`define FIELD_MODE_HI 2
`define FIELD_MODE_LO 0

`define MODE_OFF 3'h0
`define MODE_EVERY_EDGE 3'h1
`define MODE_FALLING 3'h2
`define MODE_RISING 3'h3
`define MODE_RISING_4TH 3'h4
`define MODE_RISING_16TH 3'h5
`define MODE_UNUSED 3'h6
`define MODE_WAKE_ONLY 3'h7

`define FIFO_DEPTH 3'h4
`define PRESCALE_4TH 4'h3
`define PRESCALE_16TH 4'hf

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### testbench/capture_source_model.sv
// Capture pin and the two timers seen by the channel
`default_nettype none
module capture_source_model (
    // Clock
    input wire logic mclk,
    // Pin and time bases
    output var logic pin,
    output var logic [15:0] t2,
    output var logic [15:0] t3
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin = 1'b0;
        t2 = 16'h0;
        t3 = 16'h0;
    end
    // Timers hold still so both edges of a pulse capture the same known count
    task automatic pulse(input logic [15:0] a, input logic [15:0] b);
        @(posedge mclk);
        pin <= 1'b1;
        t2 <= a;
        t3 <= b;
        repeat (3) @(posedge mclk);
        pin <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ### testbench/input_capture_control_properties.sv
// Port-level checker for the capture channel
`default_nettype none
module input_capture_control_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Bus
    input wire logic awready, wready, bvalid, bready, arvalid, arready, rvalid, rready,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata,
    // Capture side
    input wire logic capturePinIn, cpuIdle, cpuSleep, captureInterrupt, wakeInterrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    read_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0)
        else $error("upper read bits set");
    read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    write_busy_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    wake_cause_a: assert property (wakeInterrupt |-> $past(capturePinIn) &&
        !$past(capturePinIn, 2) && $past(cpuSleep || cpuIdle)) else $error("wake uncaused");
    wake_single_a: assert property (wakeInterrupt |=> !wakeInterrupt)
        else $error("wake too long");
    irq_cause_a: assert property (captureInterrupt |->
        $past(capturePinIn) != $past(capturePinIn, 2)) else $error("interrupt uncaused");
    cover property (captureInterrupt);
    cover property (wakeInterrupt);
    cover property (bvalid && bresp == 2'h2);
endmodule
bind input_capture_control input_capture_control_properties chk_i (.mclk, .srst, .awready,
    .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .bresp, .rdata,
    .capturePinIn, .cpuIdle, .cpuSleep, .captureInterrupt, .wakeInterrupt);
`default_nettype wire

// ### testbench/input_capture_control_tb.sv
// Register-level tests of the capture channel
`include "input_capture_control_defs.vh"
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module input_capture_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic cpuIdle = 0, cpuSleep = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid, captureInterrupt, wakeInterrupt, pin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] t2, t3;
    int err_total = 0, checks_done = 0, irqs = 0, wakes = 0;
    input_capture_control input_capture_control_i (.mclk, .srst, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .rvalid, .rready, .rdata, .rresp, .capturePinIn(pin),
        .secondTimerCount(t2), .thirdTimerCount(t3), .cpuIdle, .cpuSleep,
        .captureInterrupt, .wakeInterrupt);
    capture_source_model capture_source_model_i (.mclk, .pin, .t2, .t3);
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (captureInterrupt === 1'b1) irqs++;
        if (wakeInterrupt === 1'b1) wakes++;
    end
    function automatic logic [31:0] ctl(input logic h, t, input logic [1:0] f,
        input logic [2:0] m);
        return {18'h0, h, 5'h0, t, f, 2'h0, m};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        `CHK(bresp, er)
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        `CHK(rdata, ed)
        `CHK(rresp, er)
        rready <= 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Run needs well under a thousand cycles; this only catches a hung handshake
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        rd(`ADDR_CONTROL, 32'h0, `RESP_OKAY);
        wr(`ADDR_CONTROL, 32'hffff, `RESP_OKAY);
        rd(`ADDR_CONTROL, 32'h20e7, `RESP_OKAY);
        wr(8'h40, 32'h1, `RESP_SLVERR);
        wr(`ADDR_BUFFER, 32'h1, `RESP_SLVERR);
        rd(8'h40, 32'h0, `RESP_SLVERR);
        for (int n = 0; n < 4; n++) begin
            wr(`ADDR_CONTROL, ctl(0, 1, n[1:0], `MODE_RISING), `RESP_OKAY);
            irqs = 0;
            for (int k = 0; k <= n; k++) capture_source_model_i.pulse(16'h1000 + k[15:0], 16'h0);
            `CHK(irqs, 1)
            if (n == 3) capture_source_model_i.pulse(16'h1fff, 16'h0);
            rd(`ADDR_CONTROL, ctl(0, 1, n[1:0], 3) | (n == 3 ? 32'h18 : 32'h8), 0);
            for (int k = 0; k <= n; k++) rd(`ADDR_BUFFER, 32'h1000 + k, 0);
            rd(`ADDR_BUFFER, 32'h0, `RESP_OKAY);
            rd(`ADDR_CONTROL, ctl(0, 1, n[1:0], 3) | (n == 3 ? 32'h10 : 32'h0), 0);
        end
        wr(`ADDR_CONTROL, ctl(0, 1, 0, `MODE_OFF), `RESP_OKAY);
        capture_source_model_i.pulse(16'h0abc, 16'h0);
        rd(`ADDR_CONTROL, 32'h80, `RESP_OKAY);
        wr(`ADDR_CONTROL, ctl(0, 0, 0, `MODE_UNUSED), `RESP_OKAY);
        capture_source_model_i.pulse(16'h0abc, 16'h0);
        rd(`ADDR_CONTROL, 32'h6, `RESP_OKAY);
        wr(`ADDR_CONTROL, ctl(0, 0, 0, `MODE_EVERY_EDGE), `RESP_OKAY);
        irqs = 0;
        capture_source_model_i.pulse(16'h1111, 16'h2222);
        `CHK(irqs, 2)
        rd(`ADDR_BUFFER, 32'h2222, `RESP_OKAY);
        rd(`ADDR_BUFFER, 32'h2222, `RESP_OKAY);
        // Falling-edge mode captures once per pulse, on the way down
        wr(`ADDR_CONTROL, ctl(0, 0, 0, `MODE_FALLING), `RESP_OKAY);
        irqs = 0;
        capture_source_model_i.pulse(16'h0, 16'h7777);
        `CHK(irqs, 1)
        rd(`ADDR_BUFFER, 32'h7777, `RESP_OKAY);
        rd(`ADDR_CONTROL, 32'h2, `RESP_OKAY);
        // Prescaled modes keep only every 4th or 16th rising edge
        for (int s = 0; s < 2; s++) begin
            wr(`ADDR_CONTROL, ctl(0, 1, 0, `MODE_RISING_4TH + s[2:0]), `RESP_OKAY);
            irqs = 0;
            for (int k = 0; k < 4 + 12 * s; k++)
                capture_source_model_i.pulse(16'h6000 + k[15:0], 16'h0);
            `CHK(irqs, 1)
            rd(`ADDR_BUFFER, s ? 32'h600f : 32'h6003, `RESP_OKAY);
            rd(`ADDR_BUFFER, 32'h0, `RESP_OKAY);
        end
        wr(`ADDR_CONTROL, ctl(1, 1, 0, `MODE_RISING), `RESP_OKAY);
        cpuIdle <= 1'b1;
        capture_source_model_i.pulse(16'h3333, 16'h0);
        rd(`ADDR_CONTROL, 32'h2083, `RESP_OKAY);
        wr(`ADDR_CONTROL, ctl(0, 1, 0, `MODE_RISING), `RESP_OKAY);
        capture_source_model_i.pulse(16'h4444, 16'h0);
        rd(`ADDR_BUFFER, 32'h4444, `RESP_OKAY);
        wr(`ADDR_CONTROL, ctl(0, 0, 0, `MODE_WAKE_ONLY), `RESP_OKAY);
        cpuIdle <= 1'b0;
        cpuSleep <= 1'b1;
        wakes = 0;
        capture_source_model_i.pulse(16'h5555, 16'h0);
        `CHK(wakes, 1)
        // Mid-run reset with a value waiting must empty the buffer and clear control
        wr(`ADDR_CONTROL, ctl(1, 1, 3, `MODE_RISING), `RESP_OKAY);
        capture_source_model_i.pulse(16'h0bad, 16'h0);
        rd(`ADDR_CONTROL, 32'h20eb, `RESP_OKAY);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(`ADDR_CONTROL, 32'h0, `RESP_OKAY);
        rd(`ADDR_BUFFER, 32'h0, `RESP_OKAY);
        test_done;
    end
endmodule
`default_nettype wire
